//--- pio_top.sv
// Parallel I/O ports with an AHB-Lite register slave.
`timescale 1ns/10ps
`include "pio_defines.svh"
// ----------------------------------------------------------------
// Overview of operation
// RL1: 143 lines in thirteen ports of mixed width.
// RL2: Each line general I/O or peripheral-owned.
// RL3: Per-bit direction; input-only ports have none.
// RL4: Input lines leave the pad floating.
// RL5: Seven ports select push-pull or open-drain.
// RL6: Five ports select TTL or CMOS threshold.
// RL7: Pins sampled every state time.
// RL8: Input line: write latch, read pin.
// RL9: Input line modify uses pin value.
// RL10: Output line: write drives latch onto pin.
// RL11: Output line read returns latch.
// RL12: Output line modify uses latch value.
// RL13: Extended ports need both enable bits set.
// RL14: Extended ports: word access only, no bit.
// RL15: Edge control and control-line drive registers.
// RL16: Reset clears all direction bits.
// ----------------------------------------------------------------

module pio_top (
	input wire logic core_clk, // 200 MHz state time clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic clk_en, // freezes all state while low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // always OKAY
	input wire pio_pkg::pio_bus_t pin_in, // pad levels
	input wire pio_pkg::pio_alt_t alt, // peripheral claims
	output pio_pkg::pio_bus_t pin_out, // pad values
	output pio_pkg::pio_bus_t pin_oe_n, // pad enables, low drives
	output pio_pkg::pio_bus_t pin_sample, // sampled pins
	output pio_pkg::pio_bus_t edge_ctl, // output edge settings
	output logic [4:0] thr_sel, // threshold selects
	output logic [15:0] ctl_drive // control-line drive
);

	// ----------------------------------------------------------------
	// Port shapes
	// ----------------------------------------------------------------
	// Order: P0L P0H P1L P1H P2 P3 P4 P5 P6 P7 P8 ext_io ext_in.
	function automatic int port_width(input int i);
		case (i)
			4, 7, 11, 12: return 16;
			5: return 15;
			default: return 8;
		endcase
	endfunction : port_width

	function automatic bit has_dir(input int i);
		return !(i == `PIO_IDX_P5 || i == `PIO_IDX_EXT_IN);
	endfunction : has_dir

	function automatic bit has_od(input int i);
		return (i >= 4 && i <= 11 && i != `PIO_IDX_P5);
	endfunction : has_od

	function automatic bit has_edge(input int i);
		return (i <= 10 && i != `PIO_IDX_P5);
	endfunction : has_edge

	function automatic logic port_hit(input logic [9:0] a, input int i);
		return !a[9] && (a[8:5] == 4'(i));
	endfunction : port_hit

	function automatic bit is_ext(input int i);
		return (i == `PIO_IDX_EXT_IO || i == `PIO_IDX_EXT_IN);
	endfunction : is_ext

	function automatic pio_pkg::pio_wr_kind_t off_kind(input logic [4:0] o);
		case (o)
			`PIO_OFS_DIR: return pio_pkg::PIO_WR_DIR;
			`PIO_OFS_OD: return pio_pkg::PIO_WR_OD;
			`PIO_OFS_SET: return pio_pkg::PIO_WR_SET;
			`PIO_OFS_CLR: return pio_pkg::PIO_WR_CLR;
			default: return pio_pkg::PIO_WR_DATA;
		endcase
	endfunction : off_kind

	// The set and clear windows are bit operations, so the extended
	// ports refuse them and are reached a whole word at a time.
	function automatic logic off_ok(input logic [4:0] o, input bit ext);
		case (o)
			`PIO_OFS_DATA, `PIO_OFS_DIR, `PIO_OFS_OD: return 1'b1;
			`PIO_OFS_SET, `PIO_OFS_CLR: return !ext;
			default: return 1'b0;
		endcase
	endfunction : off_ok

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pio_pkg::pio_top_st_t st;
	pio_pkg::pio_top_st_t next_st;
	pio_pkg::pio_bus_t p_rd;
	pio_pkg::pio_bus_t p_dir;
	pio_pkg::pio_bus_t p_od;
	logic [12:0] p_wr;
	logic xen;
	logic [31:0] rd_word;
	logic addr_take;

	// RL13 both enables required
	assign xen = st.syscfg[`PIO_SYSCFG_XEN_BIT] && st.xcfg[`PIO_XCFG_XEN_BIT];
	assign addr_take = hsel && htrans[1] && hready;

	assign hreadyout = st.hready;
	assign hresp = st.hresp;
	assign hrdata = st.hrdata;
	assign edge_ctl = st.edge_ctl;
	assign thr_sel = st.thr;
	assign ctl_drive = st.ctl_drv;

	// ----------------------------------------------------------------
	// Ports
	// ----------------------------------------------------------------
	// RL1 thirteen ports
	for (genvar g = 0; g < `PIO_NUM_PORTS; g++) begin : g_port
		localparam bit EXT = is_ext(g);

		// RL14 no bit access on extended
		assign p_wr[g] = st.wr_pend && port_hit(st.addr, g)
			&& off_ok(st.addr[4:0], EXT);

		pio_port #(
			.WIDTH(port_width(g)),
			.HAS_DIR(has_dir(g)),
			.HAS_OD(has_od(g))
		) u_port (
			.core_clk(core_clk),
			.sys_rst(sys_rst),
			.clk_en(clk_en),
			.enable(EXT ? xen : 1'b1),
			.wr_en(p_wr[g]),
			.wr_kind(off_kind(st.addr[4:0])),
			.wdata(hwdata[15:0]),
			.pin_in(pin_in[g]),
			.alt_sel(alt.sel[g]),
			.alt_out(alt.out[g]),
			.alt_dir(alt.dir[g]),
			.rd_data(p_rd[g]),
			.rd_dir(p_dir[g]),
			.rd_od(p_od[g]),
			.sample(pin_sample[g]),
			.pin_out(pin_out[g]),
			.pin_oe_n(pin_oe_n[g])
		);
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		for (int i = 0; i < `PIO_NUM_PORTS; i++) begin
			if (port_hit(st.addr, i)) begin
				case (st.addr[4:0])
					`PIO_OFS_DATA: rd_word = {16'h0000, p_rd[i]};
					`PIO_OFS_DIR: rd_word = {16'h0000, p_dir[i]};
					`PIO_OFS_OD: rd_word = {16'h0000, p_od[i]};
					`PIO_OFS_EDGE: rd_word = {16'h0000, st.edge_ctl[i]};
					default: rd_word = 32'h0000_0000;
				endcase
			end
		end
		case (st.addr)
			`PIO_ADDR_THR: rd_word = {27'h0000000, st.thr};
			`PIO_ADDR_CTLDRV: rd_word = {16'h0000, st.ctl_drv};
			`PIO_ADDR_SYSCFG: rd_word = {16'h0000, st.syscfg};
			`PIO_ADDR_XCFG: rd_word = {16'h0000, st.xcfg};
			default: rd_word = rd_word;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus slave and global registers
	// ----------------------------------------------------------------
	// Reads take one wait state so that a write in the preceding data
	// phase is already visible; writes complete without waiting.
	always_comb begin
		next_st = st;
		next_st.hresp = 1'b0;
		if (st.rd_pend) begin
			next_st.hrdata = rd_word;
			next_st.hready = 1'b1;
			next_st.rd_pend = 1'b0;
		end
		if (st.wr_pend) begin
			next_st.wr_pend = 1'b0;
			for (int i = 0; i < `PIO_NUM_PORTS; i++) begin
				// RL15 edge control registers
				if (port_hit(st.addr, i) && st.addr[4:0] == `PIO_OFS_EDGE
					&& has_edge(i)) begin
					next_st.edge_ctl[i] = hwdata[15:0];
				end
			end
			case (st.addr)
				// RL6 threshold select
				`PIO_ADDR_THR: next_st.thr = hwdata[4:0];
				// RL15 control-line drive
				`PIO_ADDR_CTLDRV: next_st.ctl_drv = hwdata[15:0];
				`PIO_ADDR_SYSCFG: next_st.syscfg = hwdata[15:0];
				`PIO_ADDR_XCFG: next_st.xcfg = hwdata[15:0];
				default: next_st.thr = st.thr;
			endcase
		end
		if (addr_take) begin
			next_st.addr = haddr[9:0];
			if (hwrite) begin
				next_st.wr_pend = 1'b1;
			end else begin
				next_st.rd_pend = 1'b1;
				next_st.hready = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st <= '{hready: 1'b1, hresp: 1'b0, rd_pend: 1'b0,
				wr_pend: 1'b0, addr: 10'h000, hrdata: 32'h0000_0000,
				edge_ctl: '0, thr: `PIO_RST_THR,
				ctl_drv: `PIO_RST_WORD, syscfg: `PIO_RST_WORD,
				xcfg: `PIO_RST_WORD};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_ext_gate: assert property ( // RL13
		$past(clk_en) && !$past(sys_rst) && !$past(xen)
		|-> pin_oe_n[`PIO_IDX_EXT_IO] == 16'hffff
		&& p_rd[`PIO_IDX_EXT_IO] == 16'h0000 || xen)
		else $error("extended port active while disabled");
	a_read_wait: assert property (
		addr_take && !hwrite && clk_en |=> !hreadyout)
		else $error("read did not insert wait state");
	a_read_done: assert property (
		!hreadyout && clk_en |=> hreadyout && hrdata == $past(rd_word))
		else $error("read data phase not closed");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response given");
	a_thr_write: assert property ( // RL6
		st.wr_pend && st.addr == `PIO_ADDR_THR && clk_en
		|=> thr_sel == $past(hwdata[4:0]))
		else $error("threshold select not written");
	a_ctl_write: assert property ( // RL15
		st.wr_pend && st.addr == `PIO_ADDR_CTLDRV && clk_en
		|=> ctl_drive == $past(hwdata[15:0]))
		else $error("control-line drive not written");
	a_ext_no_bit: assert property ( // RL14
		st.wr_pend && st.addr[4:0] == `PIO_OFS_SET
		&& st.addr[8:5] == 4'hb |-> !p_wr[`PIO_IDX_EXT_IO])
		else $error("bit access reached extended port");

endmodule : pio_top

//--- pio_defines.svh
// Register offsets, field positions, reset values and port numbering.
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ----------------------------------------------------------------
// Port numbering
// ----------------------------------------------------------------
`define PIO_NUM_PORTS 13
`define PIO_IDX_P5 7
`define PIO_IDX_EXT_IO 11
`define PIO_IDX_EXT_IN 12

// ----------------------------------------------------------------
// Per-port register window, offsets within a 32-byte slot
// ----------------------------------------------------------------
`define PIO_OFS_DATA 5'h00
`define PIO_OFS_DIR 5'h04
`define PIO_OFS_OD 5'h08
`define PIO_OFS_EDGE 5'h0c
`define PIO_OFS_SET 5'h10
`define PIO_OFS_CLR 5'h14

// ----------------------------------------------------------------
// Global registers
// ----------------------------------------------------------------
`define PIO_ADDR_THR 10'h200
`define PIO_ADDR_CTLDRV 10'h204
`define PIO_ADDR_SYSCFG 10'h208
`define PIO_ADDR_XCFG 10'h20c
`define PIO_SYSCFG_XEN_BIT 2
`define PIO_XCFG_XEN_BIT 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIO_RST_WORD 16'h0000
`define PIO_RST_OE_N 16'hffff
`define PIO_RST_THR 5'h00

`endif

//--- pio_pkg.sv
// Types shared by the parallel port block.
package pio_pkg;

	typedef logic [12:0][15:0] pio_bus_t;

	typedef struct packed {
		pio_bus_t sel;
		pio_bus_t out;
		pio_bus_t dir;
	} pio_alt_t;

	typedef enum logic [2:0] {
		PIO_WR_DATA,
		PIO_WR_DIR,
		PIO_WR_OD,
		PIO_WR_SET,
		PIO_WR_CLR
	} pio_wr_kind_t;

	typedef struct packed {
		logic [15:0] latch;
		logic [15:0] dir;
		logic [15:0] od;
		logic [15:0] sample;
		logic [15:0] pin_out;
		logic [15:0] pin_oe_n;
	} pio_port_st_t;

	typedef struct packed {
		logic hready;
		logic hresp;
		logic rd_pend;
		logic wr_pend;
		logic [9:0] addr;
		logic [31:0] hrdata;
		pio_bus_t edge_ctl;
		logic [4:0] thr;
		logic [15:0] ctl_drv;
		logic [15:0] syscfg;
		logic [15:0] xcfg;
	} pio_top_st_t;

endpackage : pio_pkg

//--- pio_port.sv
// One parallel port: output latch, direction, open-drain and pin sampling.
`timescale 1ns/10ps
`include "pio_defines.svh"

module pio_port #(
	parameter int WIDTH = 16,
	parameter bit HAS_DIR = 1'b1,
	parameter bit HAS_OD = 1'b1
) (
	input wire logic core_clk, // state time clock
	input wire logic sys_rst, // synchronous reset
	input wire logic clk_en, // freezes state while low
	input wire logic enable, // port switched on
	input wire logic wr_en, // write strobe
	input wire pio_pkg::pio_wr_kind_t wr_kind, // which register
	input wire logic [15:0] wdata, // write data
	input wire logic [15:0] pin_in, // pad level
	input wire logic [15:0] alt_sel, // peripheral owns bit
	input wire logic [15:0] alt_out, // peripheral value
	input wire logic [15:0] alt_dir, // peripheral direction
	output logic [15:0] rd_data, // software read view
	output logic [15:0] rd_dir, // direction bits
	output logic [15:0] rd_od, // open-drain bits
	output logic [15:0] sample, // sampled pins
	output logic [15:0] pin_out, // pad drive value
	output logic [15:0] pin_oe_n // pad enable, low drives
);

	localparam logic [15:0] MASK = 16'((32'h1 << WIDTH) - 1);

	pio_pkg::pio_port_st_t st;
	pio_pkg::pio_port_st_t next_st;
	logic [15:0] view;
	logic [15:0] drv_dir;
	logic [15:0] drv_val;

	// RL8 read returns pin
	// RL11 read returns latch
	assign view = (st.dir & st.latch) | (~st.dir & st.sample);
	assign rd_data = enable ? view : 16'h0000;
	assign rd_dir = st.dir;
	assign rd_od = st.od;
	assign sample = st.sample;
	assign pin_out = st.pin_out;
	assign pin_oe_n = st.pin_oe_n;

	always_comb begin
		next_st = st;
		// RL7 sample every state
		next_st.sample = pin_in & MASK;
		if (enable && wr_en) begin
			case (wr_kind)
				// RL10 load output latch
				pio_pkg::PIO_WR_DATA: next_st.latch = wdata & MASK;
				pio_pkg::PIO_WR_DIR: next_st.dir = wdata & MASK;
				pio_pkg::PIO_WR_OD: next_st.od = wdata & MASK;
				// RL9 RL12 modify read view
				pio_pkg::PIO_WR_SET: next_st.latch = (view | wdata) & MASK;
				pio_pkg::PIO_WR_CLR: next_st.latch = (view & ~wdata) & MASK;
				default: next_st.latch = st.latch;
			endcase
		end
		// RL3 no direction control
		if (!HAS_DIR) begin
			next_st.dir = 16'h0000;
		end
		// RL5 open-drain only where present
		if (!HAS_OD) begin
			next_st.od = 16'h0000;
		end
		// RL2 peripheral takes over line
		drv_dir = (alt_sel & alt_dir) | (~alt_sel & next_st.dir);
		drv_val = (alt_sel & alt_out) | (~alt_sel & next_st.latch);
		if (!HAS_DIR) begin
			drv_dir = 16'h0000;
		end
		next_st.pin_out = drv_val & MASK;
		// RL4 inputs float
		// RL5 open drain releases high
		if (enable) begin
			next_st.pin_oe_n = ~(drv_dir & ~(next_st.od & drv_val) & MASK);
		end else begin
			next_st.pin_oe_n = `PIO_RST_OE_N;
		end
	end

	// RL16 direction clears on reset
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st <= '{latch: `PIO_RST_WORD, dir: `PIO_RST_WORD,
				od: `PIO_RST_WORD, sample: `PIO_RST_WORD,
				pin_out: `PIO_RST_WORD, pin_oe_n: `PIO_RST_OE_N};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_dir_reset: assert property ($past(sys_rst) |-> st.dir == 16'h0000 // RL16
		&& st.pin_oe_n == 16'hffff)
		else $error("direction not cleared after reset");
	a_no_dir: assert property (!HAS_DIR |-> st.pin_oe_n == 16'hffff) // RL3
		else $error("input-only port drives a pin");
	a_sample_pin: assert property ( // RL7
		$past(clk_en) && !$past(sys_rst) |-> st.sample == ($past(pin_in) & MASK))
		else $error("pin level not sampled");
	a_input_hiz: assert property ( // RL4
		$past(clk_en) && !$past(sys_rst) && $past(alt_sel) == 16'h0000
		|-> (~st.dir & ~st.pin_oe_n) == 16'h0000)
		else $error("input line is driven");
	a_od_release: assert property ( // RL5
		$past(clk_en) && !$past(sys_rst) && $past(alt_sel) == 16'h0000
		|-> (st.od & st.latch & ~st.pin_oe_n) == 16'h0000)
		else $error("open-drain line drives high");
	a_write_latch: assert property ( // RL10
		enable && wr_en && clk_en && wr_kind == pio_pkg::PIO_WR_DATA
		|=> st.latch == ($past(wdata) & MASK))
		else $error("output latch not written");
	a_rmw_set: assert property ( // RL9
		enable && wr_en && clk_en && wr_kind == pio_pkg::PIO_WR_SET
		|=> st.latch == (($past(rd_data) | $past(wdata)) & MASK))
		else $error("set does not use read view");
	a_out_drive: assert property ( // RL10
		enable && clk_en && alt_sel == 16'h0000 && HAS_DIR
		##1 (st.dir & ~st.od) == MASK
		|-> st.pin_oe_n == ~MASK && st.pin_out == st.latch)
		else $error("output line not driven with latch");

endmodule : pio_port

//--- pio_pin_load.sv
// External pin loads that close the loop from pad drive back to pad level.
`timescale 1ns/10ps

module pio_pin_load (
	input wire pio_pkg::pio_bus_t pin_out, // pad values
	input wire pio_pkg::pio_bus_t pin_oe_n, // pad enables, low drives
	input wire pio_pkg::pio_bus_t ext_level, // level of outside source
	output pio_pkg::pio_bus_t pin_in // level seen at the pad
);
	// ------------------------------------------------------------
	// Pad level
	// ------------------------------------------------------------
	// released pads follow load.
	// A released pad shows the outside source, never the last driven value,
	// so a design that forgets to release a pad is seen at once.
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : pio_pin_load

//--- parallel_io_ports_tb.sv
// Self-checking testbench for the parallel port block.
`timescale 1ns/10ps
`define CMP(a, b) cmp_val(32'(a), 32'(b))

module parallel_io_ports_tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hrdata;
	logic hready, hreadyout, hresp;
	pio_pkg::pio_bus_t pin_in, pin_out, pin_oe_n, pin_sample, edge_ctl;
	pio_pkg::pio_bus_t ext = '0;
	pio_pkg::pio_alt_t alt = '0;
	logic [4:0] thr_sel;
	logic [15:0] ctl_drive;
	int bad_count = 0;
	int num_checks = 0;
	int lat[13], dr[13], od[13];
	int wd[13] = '{8, 8, 8, 8, 16, 15, 8, 16, 8, 8, 8, 16, 16};
	bit xen = 1'b0;

	always #2.5 core_clk = ~core_clk;
	assign hready = hreadyout;

	pio_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.pin_in(pin_in), .alt(alt), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pin_sample(pin_sample), .edge_ctl(edge_ctl), .thr_sel(thr_sel),
		.ctl_drive(ctl_drive));

	pio_pin_load load (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_level(ext), .pin_in(pin_in));

	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	function automatic int msk(input int p);
		return (1 << wd[p]) - 1;
	endfunction : msk

	function automatic int rv(input int p);
		return msk(p) & ((lat[p] & dr[p]) | (int'(ext[p]) & ~dr[p]));
	endfunction : rv

	// ------------------------------------------------------------
	// Bus master and comparison
	// ------------------------------------------------------------
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp_val

	// Ready is looked at half a cycle early; it only moves on a rising edge.
	task automatic wait_rdy(output logic [31:0] r);
		logic k;
		do begin
			@(negedge core_clk);
			k = hreadyout;
			r = hrdata;
			@(posedge core_clk);
		end while (k !== 1'b1);
	endtask : wait_rdy

	task automatic xfer(input logic w, input int a, input int d,
		output logic [31:0] r);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy(r);
		htrans <= 2'h0;
		hwdata <= 32'(d);
		wait_rdy(r);
	endtask : xfer

	task automatic wr(input int a, input int d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask : wr

	task automatic rd_chk(input int a, input int e);
		logic [31:0] r;
		xfer(1'b0, a, 0, r);
		`CMP(r, e);
	endtask : rd_chk

	task automatic pw(input int p, input int ofs, input int v);
		wr(p * 32 + ofs, v);
		if (p >= 11 && !xen) return;
		case (ofs)
			0: lat[p] = v & msk(p);
			4: if (p != 7 && p != 12) dr[p] = v & msk(p);
			8: if (p inside {4, 5, 6, 8, 9, 10, 11}) od[p] = v & msk(p);
			16: if (p < 11) lat[p] = (rv(p) | v) & msk(p);
			20: if (p < 11) lat[p] = rv(p) & ~v & msk(p);
			default: ;
		endcase
	endtask : pw

	task automatic check_port(input int p);
		int oe;
		oe = ~(dr[p] & ~(od[p] & lat[p]) & msk(p)) & 16'hffff;
		// Pads move at the write edge; the sample follows one edge later.
		repeat (2) @(negedge core_clk);
		`CMP(pin_oe_n[p], oe);
		`CMP(pin_out[p] & ~pin_oe_n[p], lat[p] & ~oe);
		`CMP(pin_sample[p], msk(p) & ((lat[p] & ~oe) | (ext[p] & oe)));
		rd_chk(p * 32, rv(p));
		rd_chk(p * 32 + 4, dr[p]);
		rd_chk(p * 32 + 8, od[p]);
	endtask : check_port

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		int v;
		int seed;
		seed = $urandom(32'h3501);
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		for (int p = 0; p < 13; p++) begin
			`CMP(pin_oe_n[p], 16'hffff);
		end
		rd_chk(4 * 32 + 4, 0);
		// The extended port must stay dead until both enables are set.
		pw(11, 4, 16'hffff);
		pw(11, 0, 16'h5a5a);
		rd_chk(11 * 32, 0);
		wr(10'h208, 4);
		pw(11, 4, 16'hffff);
		rd_chk(11 * 32 + 4, 0);
		wr(10'h20c, 8);
		xen = 1'b1;
		rd_chk(11 * 32 + 4, 0);
		for (int p = 0; p < 13; p++) begin
			ext[p] <= 16'($urandom);
			pw(p, 4, $urandom);
			pw(p, 8, $urandom);
			pw(p, 0, $urandom);
			check_port(p);
			pw(p, 16, $urandom);
			check_port(p);
			pw(p, 20, $urandom);
			pw(p, 4, 16'hffff);
			pw(p, 8, 0);
			check_port(p);
		end
		v = $urandom;
		wr(10'h200, v);
		wr(10'h204, v);
		wr(4 * 32 + 12, v);
		@(negedge core_clk);
		`CMP(thr_sel, v & 5'h1f);
		`CMP(ctl_drive, v & 16'hffff);
		`CMP(edge_ctl[4], v & 16'hffff);
		rd_chk(10'h200, v & 32'h1f);
		rd_chk(10'h204, v & 32'hffff);
		rd_chk(4 * 32 + 12, v & 32'hffff);
		wr(10'h1a0, v);
		rd_chk(10'h1a0, 0);
		// A peripheral claim drives the pad while the direction bit is 0.
		pw(4, 4, 0);
		pw(4, 8, 0);
		alt.sel[4][0] <= 1'b1;
		alt.dir[4][0] <= 1'b1;
		alt.out[4][0] <= 1'b1;
		repeat (2) @(negedge core_clk);
		`CMP(pin_oe_n[4][0], 1'b0);
		`CMP(pin_out[4][0], 1'b1);
		report_and_stop;
	end

	initial begin
		#100000;
		bad_count++;
		report_and_stop;
	end
endmodule : parallel_io_ports_tb
